// ===== hdl/useq_pkg.sv
// Package with widths, sizes, reset values and encodings for the micro-instruction sequencer.
package useq_pkg;
  localparam int ADDR_W = 14;
  localparam int INSTR_W = 16;
  localparam int BITADDR_W = 24;
  localparam int TOP_W = 4;
  localparam int TOP_SHIFT = 9;
  localparam int WORD_SHIFT = 4;
  localparam int CM_WORDS = 2048;
  localparam int CM_IDX_W = 11;
  localparam int DISP_W = 12;
  localparam logic [13:0] ADDR_RST = 14'h0000;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [3:0] TOP_RST = 4'h0;
  localparam logic [23:0] BASE_RST = 24'h000000;
  localparam logic [23:0] LIMIT_RST = 24'hffffff;
  localparam logic [13:0] ADDR_ONE = 14'h0001;
  // Micro-instruction classes; all but OP_PLAIN stop overlap of the fetch with main memory work.
  typedef enum logic [2:0] {
    OP_PLAIN, OP_READ, OP_WRITE, OP_DISPATCH, OP_OVERLAY
  } op_class_t;
  // Sequencer states.
  typedef enum logic [1:0] {
    ST_FETCH, ST_MAIN_WAIT, ST_EXEC
  } seq_state_t;
endpackage

// ===== hdl/microinstruction_fetch_sequencer.sv
// Micro-instruction fetch and sequencing logic with control memory and main-memory fetch.
`timescale 1ns/1ps
// Summary of operation
// - Each fetch adds one to the micro-address, then the fetched instruction executes.
// - Before each fetch, compare micro-address with top limit times 512.
// - Below the limit, fetch from control memory at the micro-address.
// - Otherwise fetch from main memory at bit address address*16 plus base.
// - Main bit address at or above size limit raises out-of-bounds interrupt.
// - Control memory holds up to 2048 words of 16 bits each.
// - Control fetch overlaps main memory work except Read, Write, Dispatch, Overlay.
// - Control memory is written only by Overlay or console tape mode.
// - Instruction register is 16 bits; wider moves keep the rightmost 16.
// - Control-memory fetches are ORed into the instruction register contents.
// - In halt/display mode the window reads the word at the micro-address.
// - In tape mode the window is written by literal or register moves.
// - The micro-address register is 14 bits wide.
// - Relative branches add or subtract a displacement 0 to 4095.
// - Top limit is a 4-bit register scaled by 512.
// - Main microcode base is a 24-bit register holding a bit address.
module microinstruction_fetch_sequencer (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register moves from the datapath.
  input wire logic i_addr_wr,
  input wire logic [23:0] i_wr_data,
  input wire logic i_instr_wr,
  input wire logic i_top_wr,
  input wire logic i_base_wr,
  input wire logic i_limit_wr,
  input wire logic i_window_wr,
  input wire logic i_window_rd,
  // Branch control.
  input wire logic i_branch,
  input wire logic i_branch_back,
  input wire logic [11:0] i_branch_disp,
  // Execution handshake and class of current instruction.
  input wire logic i_exec_done,
  input wire useq_pkg::op_class_t i_op_class,
  input wire logic i_main_busy,
  // Console mode pins, from outside this clock domain.
  input wire logic i_halt_display,
  input wire logic i_tape_mode,
  // Main memory fetch port.
  output logic o_main_req,
  output logic [23:0] o_main_bitaddr,
  input wire logic i_main_ack,
  input wire logic [15:0] i_main_data,
  // Overlay writes into control memory.
  input wire logic i_overlay_wr,
  input wire logic [10:0] i_overlay_addr,
  input wire logic [15:0] i_overlay_data,
  // Visible state.
  output logic [15:0] o_instr,
  output logic o_instr_valid,
  output logic [13:0] o_addr,
  output logic [3:0] o_top,
  output logic [23:0] o_base,
  output logic [15:0] o_window,
  output logic o_oob_irq
);
  logic [13:0] addr_ff;
  logic [15:0] instr_ff;
  logic [3:0] top_ff;
  logic [23:0] base_ff;
  logic [23:0] limit_ff;
  logic [15:0] window_ff;
  logic instr_valid_ff;
  logic oob_ff;
  logic main_req_ff;
  logic [23:0] main_addr_ff;
  useq_pkg::seq_state_t state_ff;
  logic [1:0] halt_sync_ff;
  logic [1:0] tape_sync_ff;
  logic [15:0] cm_mem [useq_pkg::CM_WORDS];
  logic [13:0] scaled_top;
  logic use_cm;
  logic [23:0] bit_addr;
  logic no_overlap;
  logic fetch_go;
  logic [13:0] nxt_addr;

  // Console mode pins pass two flip-flops before use.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      halt_sync_ff <= 2'h0;
      tape_sync_ff <= 2'h0;
    end else begin
      halt_sync_ff <= {halt_sync_ff[0], i_halt_display};
      tape_sync_ff <= {tape_sync_ff[0], i_tape_mode};
    end
  end

  // Scaled limit, source choice and main-memory bit address.
  assign scaled_top = {1'b0, top_ff, 9'h000};
  assign use_cm = (addr_ff < scaled_top);
  assign bit_addr = {6'h00, addr_ff, 4'h0} + base_ff;
  // Read, Write, Dispatch and Overlay hold the fetch until main memory is idle.
  assign no_overlap = (i_op_class != useq_pkg::OP_PLAIN) && i_main_busy;
  assign fetch_go = (state_ff == useq_pkg::ST_FETCH) && !no_overlap;

  // Micro-address: write, relative branch or increment on fetch.
  always_comb begin
    nxt_addr = addr_ff;
    if (i_addr_wr) begin
      nxt_addr = i_wr_data[17:4];
    end else if (i_branch && state_ff == useq_pkg::ST_EXEC && i_exec_done) begin
      if (i_branch_back) begin
        nxt_addr = addr_ff - {2'h0, i_branch_disp};
      end else begin
        nxt_addr = addr_ff + {2'h0, i_branch_disp};
      end
    end else if (fetch_go && (use_cm || bit_addr < limit_ff)) begin
      nxt_addr = addr_ff + useq_pkg::ADDR_ONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      addr_ff <= useq_pkg::ADDR_RST;
    end else begin
      addr_ff <= nxt_addr;
    end
  end

  // Sequencer: fetch, wait on main memory, execute.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= useq_pkg::ST_FETCH;
      instr_valid_ff <= 1'b0;
      main_req_ff <= 1'b0;
      main_addr_ff <= 24'h000000;
      oob_ff <= 1'b0;
    end else begin
      oob_ff <= 1'b0;
      unique case (state_ff)
        useq_pkg::ST_FETCH: begin
          if (fetch_go && use_cm) begin
            state_ff <= useq_pkg::ST_EXEC;
            instr_valid_ff <= 1'b1;
          end else if (fetch_go && bit_addr >= limit_ff) begin
            oob_ff <= 1'b1;
          end else if (fetch_go) begin
            main_req_ff <= 1'b1;
            main_addr_ff <= bit_addr;
            state_ff <= useq_pkg::ST_MAIN_WAIT;
          end
        end
        useq_pkg::ST_MAIN_WAIT: begin
          if (i_main_ack) begin
            main_req_ff <= 1'b0;
            instr_valid_ff <= 1'b1;
            state_ff <= useq_pkg::ST_EXEC;
          end
        end
        useq_pkg::ST_EXEC: begin
          if (i_exec_done) begin
            instr_valid_ff <= 1'b0;
            state_ff <= useq_pkg::ST_FETCH;
          end
        end
      endcase
    end
  end

  // Instruction register: moves keep low 16 bits, control fetches OR in.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      instr_ff <= useq_pkg::INSTR_RST;
    end else if (i_instr_wr) begin
      instr_ff <= i_wr_data[15:0];
    end else if (fetch_go && use_cm) begin
      instr_ff <= instr_ff | cm_mem[addr_ff[10:0]];
    end else if (state_ff == useq_pkg::ST_MAIN_WAIT && i_main_ack) begin
      instr_ff <= i_main_data;
    end
  end

  // Top limit, base and size limit registers.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      top_ff <= useq_pkg::TOP_RST;
      base_ff <= useq_pkg::BASE_RST;
      limit_ff <= useq_pkg::LIMIT_RST;
    end else begin
      if (i_top_wr) begin
        top_ff <= i_wr_data[3:0];
      end
      if (i_base_wr) begin
        base_ff <= i_wr_data;
      end
      if (i_limit_wr) begin
        limit_ff <= i_wr_data;
      end
    end
  end

  // Control memory: written by overlay, or console window in tape mode.
  always_ff @(posedge i_clk) begin
    if (i_overlay_wr) begin
      cm_mem[i_overlay_addr] <= i_overlay_data;
    end else if (i_window_wr && tape_sync_ff[1]) begin
      cm_mem[addr_ff[10:0]] <= i_wr_data[15:0];
    end
  end

  // Window read in halt/display mode returns the word at the micro-address.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      window_ff <= 16'h0000;
    end else if (i_window_rd && halt_sync_ff[1]) begin
      window_ff <= cm_mem[addr_ff[10:0]];
    end
  end

  // Outputs come straight from flip-flops.
  assign o_instr = instr_ff;
  assign o_instr_valid = instr_valid_ff;
  assign o_addr = addr_ff;
  assign o_top = top_ff;
  assign o_base = base_ff;
  assign o_window = window_ff;
  assign o_oob_irq = oob_ff;
  assign o_main_req = main_req_ff;
  assign o_main_bitaddr = main_addr_ff;

  // Checks on the fetch behaviour, instruction-register moves and forward branches.
  sequence s_cm_fetch;
    fetch_go && use_cm;
  endsequence

  // Answer to a main-memory fetch: the acknowledge arrives in the wait state.
  sequence s_main_ack;
    state_ff == useq_pkg::ST_MAIN_WAIT && i_main_ack;
  endsequence

  a_incr_on_fetch: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_cm_fetch and !i_addr_wr |=> addr_ff == $past(addr_ff) + 14'h0001)
    else $error("Micro-address did not advance on fetch.");
  a_cm_exec: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_cm_fetch |=> state_ff == useq_pkg::ST_EXEC && instr_valid_ff)
    else $error("Control fetch did not enter execute.");
  a_main_addr: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(main_req_ff) |-> main_addr_ff == $past(bit_addr) && !$past(use_cm))
    else $error("Main fetch address wrong.");
  a_oob_raise: assert property (@(posedge i_clk) disable iff (!i_rstn)
    fetch_go && !use_cm && bit_addr >= limit_ff |=> oob_ff && !main_req_ff)
    else $error("Out-of-bounds fetch not flagged.");
  a_no_overlap: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_ff == useq_pkg::ST_FETCH && i_op_class != useq_pkg::OP_PLAIN && i_main_busy
      |=> state_ff == useq_pkg::ST_FETCH)
    else $error("Fetch overlapped a non-overlapped instruction.");
  a_instr_or: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_cm_fetch and !i_instr_wr |=> (instr_ff & $past(instr_ff)) == $past(instr_ff))
    else $error("Instruction register lost bits on fetch.");
  a_instr_move: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_instr_wr |=> instr_ff == $past(i_wr_data[15:0]))
    else $error("Move into instruction register wrong.");
  a_branch_add: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_branch && !i_branch_back && !i_addr_wr && state_ff == useq_pkg::ST_EXEC && i_exec_done
      |=> addr_ff == $past(addr_ff) + {2'h0, $past(i_branch_disp)})
    else $error("Relative branch address wrong.");
  a_top_scale: assert property (@(posedge i_clk) disable iff (!i_rstn)
    use_cm == ({1'b0, top_ff, 9'h000} > addr_ff))
    else $error("Source choice disagrees with scaled top limit.");

  // Checks on main fetches, refusals, branches, register moves, execute release, window hold and plain fetches.
  a_main_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_main_ack and !i_instr_wr |=> instr_ff == $past(i_main_data) && instr_valid_ff)
    else $error("Main fetch did not load the instruction.");
  a_main_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_ff == useq_pkg::ST_MAIN_WAIT && !i_main_ack
      |=> main_req_ff && state_ff == useq_pkg::ST_MAIN_WAIT)
    else $error("Main request dropped before its answer.");
  a_oob_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    fetch_go && !use_cm && bit_addr >= limit_ff && !i_addr_wr |=> addr_ff == $past(addr_ff))
    else $error("Refused fetch moved the micro-address.");
  a_branch_sub: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_branch && i_branch_back && !i_addr_wr && state_ff == useq_pkg::ST_EXEC && i_exec_done
      |=> addr_ff == $past(addr_ff) - {2'h0, $past(i_branch_disp)})
    else $error("Backward branch address wrong.");
  a_exec_release: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_ff == useq_pkg::ST_EXEC && i_exec_done |=> state_ff == useq_pkg::ST_FETCH && !instr_valid_ff)
    else $error("Finished instruction did not release the sequencer.");
  a_window_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !(i_window_rd && halt_sync_ff[1]) |=> $stable(window_ff))
    else $error("Window changed without a console read.");
  a_addr_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_addr_wr |=> addr_ff == $past(i_wr_data[17:4]))
    else $error("Move into micro-address wrong.");
  a_top_move: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_top_wr |=> top_ff == $past(i_wr_data[3:0]))
    else $error("Move into top limit wrong.");
  a_base_move: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_base_wr |=> base_ff == $past(i_wr_data))
    else $error("Move into microcode base wrong.");
  a_plain_fetch: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_ff == useq_pkg::ST_FETCH && i_op_class == useq_pkg::OP_PLAIN
      |=> state_ff != useq_pkg::ST_FETCH || oob_ff)
    else $error("Plain instruction fetch was held back.");
endmodule

// ===== verif/main_memory_model.sv
// Behavioural main memory that answers micro-instruction fetch requests.
`timescale 1ns/1ps
module main_memory_model (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Fetch port.
  input wire logic i_req,
  input wire logic [23:0] i_bitaddr,
  output logic o_ack,
  output logic [15:0] o_data,
  output logic [23:0] o_last_addr
);
  logic [1:0] wait_ff;
  // Answers after a fixed wait; the data lines toggle outside the answer cycle.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_ff <= 2'h0;
      o_ack <= 1'b0;
      o_data <= 16'h0000;
      o_last_addr <= 24'h000000;
    end else if (i_req && !o_ack && wait_ff == 2'h2) begin
      o_ack <= 1'b1;
      o_data <= i_bitaddr[19:4] ^ 16'h5a5a;
      o_last_addr <= i_bitaddr;
      wait_ff <= 2'h0;
    end else begin
      o_ack <= 1'b0;
      o_data <= ~o_data;
      if (i_req && !o_ack) begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule

// ===== verif/microinstruction_fetch_sequencer_tb_top.sv
// Self-checking bench for the micro-instruction fetch sequencer.
`timescale 1ns/1ps
module microinstruction_fetch_sequencer_tb_top;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_exec_done = 1'b0, i_main_busy = 1'b0;
  logic i_addr_wr = 1'b0, i_instr_wr = 1'b0, i_top_wr = 1'b0, i_base_wr = 1'b0;
  logic i_limit_wr = 1'b0, i_window_wr = 1'b0, i_window_rd = 1'b0, i_overlay_wr = 1'b0;
  logic i_branch = 1'b0, i_branch_back = 1'b0, i_halt_display = 1'b0, i_tape_mode = 1'b0;
  logic [23:0] i_wr_data = 24'h000000;
  logic [11:0] i_branch_disp = 12'h000;
  logic [10:0] i_overlay_addr = 11'h000;
  logic [15:0] i_overlay_data = 16'h0000, o_instr, o_window, main_data, mval;
  useq_pkg::op_class_t i_op_class = useq_pkg::OP_PLAIN;
  logic o_main_req, o_instr_valid, o_oob_irq, main_ack, seen;
  logic [23:0] o_main_bitaddr, o_base, last_addr;
  logic [13:0] o_addr;
  logic [3:0] o_top;
  int error_cnt = 0, num_checks = 0;
  // Clock at 10 MHz.
  always #50 i_clk = ~i_clk;
  microinstruction_fetch_sequencer DUT (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_addr_wr(i_addr_wr), .i_wr_data(i_wr_data), .i_instr_wr(i_instr_wr),
    .i_top_wr(i_top_wr), .i_base_wr(i_base_wr), .i_limit_wr(i_limit_wr),
    .i_window_wr(i_window_wr), .i_window_rd(i_window_rd), .i_branch(i_branch),
    .i_branch_back(i_branch_back), .i_branch_disp(i_branch_disp),
    .i_exec_done(i_exec_done), .i_op_class(i_op_class), .i_main_busy(i_main_busy),
    .i_halt_display(i_halt_display), .i_tape_mode(i_tape_mode),
    .o_main_req(o_main_req), .o_main_bitaddr(o_main_bitaddr), .i_main_ack(main_ack),
    .i_main_data(main_data), .i_overlay_wr(i_overlay_wr),
    .i_overlay_addr(i_overlay_addr), .i_overlay_data(i_overlay_data),
    .o_instr(o_instr), .o_instr_valid(o_instr_valid), .o_addr(o_addr), .o_top(o_top),
    .o_base(o_base), .o_window(o_window), .o_oob_irq(o_oob_irq));
  main_memory_model mem (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(o_main_req),
    .i_bitaddr(o_main_bitaddr), .o_ack(main_ack), .o_data(main_data),
    .o_last_addr(last_addr));
  // Prints the verdict and ends the run.
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Compares one seen value with its expectation.
  task automatic chk(input logic [23:0] seen_v, input logic [23:0] exp_v);
    num_checks++;
    if (seen_v !== exp_v) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  // Waits a bounded time for a valid instruction.
  task automatic wait_valid();
    for (int n = 0; n < 60; n++) begin
      @(posedge i_clk);
      #1;
      if (o_instr_valid === 1'b1) return;
    end
    error_cnt++;
    conclude();
  endtask
  // Writes one register; sel picks addr, instr, top, base, limit, window, overlay.
  task automatic wr(input int sel, input logic [23:0] d);
    @(posedge i_clk);
    i_wr_data <= d;
    i_overlay_data <= d[15:0];
    i_addr_wr <= (sel == 0);
    i_instr_wr <= (sel == 1);
    i_top_wr <= (sel == 2);
    i_base_wr <= (sel == 3);
    i_limit_wr <= (sel == 4);
    i_window_wr <= (sel == 5);
    i_overlay_wr <= (sel == 6);
    @(posedge i_clk);
    {i_addr_wr, i_instr_wr, i_top_wr, i_base_wr} <= 4'h0;
    {i_limit_wr, i_window_wr, i_overlay_wr} <= 3'h0;
    #1;
  endtask
  // Finishes the current instruction with an optional branch.
  task automatic step(input logic br, input logic back, input logic [11:0] disp);
    @(posedge i_clk);
    i_exec_done <= 1'b1;
    i_branch <= br;
    i_branch_back <= back;
    i_branch_disp <= disp;
    @(posedge i_clk);
    i_exec_done <= 1'b0;
    i_branch <= 1'b0;
  endtask
  // Main sequence of scenarios.
  initial begin
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1;
    chk(o_addr, 24'h0);
    chk(o_instr, 24'h0);
    wait_valid();
    chk(last_addr, 24'h0);
    chk(o_addr, 24'h1);
    chk(o_instr, 16'h5a5a);
    i_overlay_addr <= 11'h001;
    wr(6, 24'h001234);
    wr(2, 24'h000001);
    chk(o_top, 24'h1);
    wr(1, 24'hab0f00);
    chk(o_instr, 16'h0f00);
    i_op_class <= useq_pkg::OP_READ;
    i_main_busy <= 1'b1;
    step(1'b0, 1'b0, 12'h000);
    repeat (4) @(posedge i_clk);
    #1;
    chk(o_instr_valid, 24'h0);
    i_main_busy <= 1'b0;
    wait_valid();
    chk(o_instr, 16'h1f34);
    chk(o_addr, 24'h2);
    i_tape_mode <= 1'b1;
    repeat (3) @(posedge i_clk);
    wr(5, 24'h0000f0);
    i_tape_mode <= 1'b0;
    i_halt_display <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_window_rd <= 1'b1;
    @(posedge i_clk);
    i_window_rd <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(o_window, 16'h00f0);
    i_halt_display <= 1'b0;
    i_overlay_addr <= 11'h1ff;
    wr(6, 24'h000000);
    wr(0, 24'h001ff0);
    wr(3, 24'h000100);
    chk(o_base, 24'h000100);
    step(1'b0, 1'b0, 12'h000);
    wait_valid();
    chk(o_addr, 24'h200);
    chk(o_instr, 16'h1f34);
    step(1'b1, 1'b0, 12'h001);
    wait_valid();
    chk(last_addr, 24'h002110);
    chk(o_main_bitaddr, 24'h002110);
    mval = 16'h0211 ^ 16'h5a5a;
    chk(o_instr, mval);
    step(1'b1, 1'b1, 12'h201);
    wait_valid();
    chk(o_addr, 24'h2);
    chk(o_instr, mval | 16'h1234);
    wr(0, 24'h03fff0);
    wr(4, 24'h0100f0);
    step(1'b0, 1'b0, 12'h000);
    seen = 1'b0;
    for (int n = 0; n < 20; n++) begin
      @(posedge i_clk);
      #1;
      if (o_oob_irq === 1'b1) seen = 1'b1;
    end
    chk(seen, 24'h1);
    chk(o_addr, 24'h3fff);
    chk(o_instr_valid, 24'h0);
    conclude();
  end
endmodule
